// *** dv/raw_data_capture_channel_tb.sv ***
// self-checking bench for the raw data capture channel
`timescale 1ns/1ps
module raw_data_capture_channel_tb;
	localparam logic [7:0] rc = raw_capture_pkg::ctrl_off;
	localparam logic [7:0] rs = raw_capture_pkg::stop_off;
	localparam logic [7:0] rt = raw_capture_pkg::thrld_off;
	localparam logic [7:0] rst = raw_capture_pkg::status_off;
	localparam logic [7:0] rn = raw_capture_pkg::count_off;
	localparam logic [7:0] rl = raw_capture_pkg::luma_off;
	localparam logic [31:0] full = 32'hFFFFFFFF;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic port_clock, capture_qualify, field_identity_input, vertical_blank, line_start;
	logic luma_dma_event, capture_complete_irq_flag;
	logic [7:0] raw_data;
	int n_errors = 0, num_checks = 0, cycles = 0, n_evt = 0;
	assign hready = hreadyout;
	////////////////////////////////////////////////
	raw_data_capture_channel #(.DATA_WIDTH(8), .CHANNEL_A(1'b1)) u_raw_data_capture_channel (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_clock(port_clock),
		.capture_qualify(capture_qualify), .raw_data(raw_data),
		.field_identity_input(field_identity_input), .vertical_blank(vertical_blank),
		.line_start(line_start), .luma_dma_event(luma_dma_event),
		.capture_complete_irq_flag(capture_complete_irq_flag)
	);
	raw_source_model #(.W(8)) u_raw_source_model (
		.port_clock(port_clock), .capture_qualify(capture_qualify), .raw_data(raw_data)
	);
	// clock, event counter and hang guard
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// dma pulses counted mid-cycle, away from the edge that launches them
	always @(negedge hclk) begin
		if (luma_dma_event === 1'b1) n_evt++;
	end
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end
	////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask : chk
	// one single transfer; waits on hready, no fixed latency assumed
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rdv = hrdata;
	endtask : xfer
	task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(a, 1'b0, 32'h00000000);
		chk(rdv & m, e, "register read");
	endtask : rdc
	// reads n samples from the luma port, oldest first
	task drain(input int n, input logic [7:0] f);
		int i;
		for (i = 0; i < n; i++) rdc(rl, full, {24'h000000, f + 8'(i)});
	endtask : drain
	task setup(input logic [31:0] stop, input logic [31:0] thr, input logic [31:0] ctl);
		xfer(rc, 1'b1, 32'h00000000);
		xfer(rst, 1'b1, 32'h0000001F);
		xfer(rs, 1'b1, stop);
		xfer(rt, 1'b1, thr);
		xfer(rc, 1'b1, ctl);
	endtask : setup
	// level pulses on the blanking or line pin, long enough for the synchronisers
	task pulses(input int n, input bit vb);
		repeat (n) begin
			@(posedge hclk);
			if (vb) vertical_blank <= 1'b1;
			else line_start <= 1'b1;
			repeat (8) @(posedge hclk);
			vertical_blank <= 1'b0;
			line_start <= 1'b0;
			repeat (8) @(posedge hclk);
		end
	endtask : pulses
	////////////////////////////////////////////////
	task t_reset;
		rdc(rc, full, 32'h00000000);
		rdc(rs, full, 32'h00000000);
		rdc(rt, full, 32'h00000000);
		rdc(rst, 32'h00000F1F, 32'h00000000);
		rdc(rn, full, 32'h00000000);
		rdc(8'h18, full, 32'h00000000);
		chk({31'h0, capture_complete_irq_flag}, 32'h0, "irq at reset");
		chk({30'h0, hreadyout, hresp}, 32'h2, "bus answer");
		$display("test reset ended");
	endtask : t_reset
	// continuous capture with filter bits set; edge data values 0xFE..0x01
	task t_cont;
		setup(32'h4, 32'h0, 32'h305);
		u_raw_source_model.send(4, 8'hFE, 1'b1);
		rdc(rst, 32'h31F, 32'h30C);
		chk({31'h0, capture_complete_irq_flag}, 32'h1, "irq");
		rdc(rn, full, 32'h0);
		drain(4, 8'hFE);
		xfer(rl, 1'b1, 32'h00000055);
		rdc(rl, full, 32'h0);
		u_raw_source_model.send(4, 8'h10, 1'b1);
		rdc(rst, 32'h31F, 32'h30C);
		drain(4, 8'h10);
		$display("test continuous ended");
	endtask : t_cont
	// stop value with a non-zero upper half must not end after 3 samples
	task t_split;
		setup(32'h1003, 32'h0, 32'h5);
		u_raw_source_model.send(3, 8'h20, 1'b1);
		rdc(rn, full, 32'h3);
		rdc(rst, 32'h1F, 32'h0);
		drain(3, 8'h20);
		xfer(rc, 1'b1, 32'h0);
		rdc(rn, full, 32'h0);
		$display("test split ended");
	endtask : t_split
	task t_single;
		setup(32'h2, 32'h0, 32'h9);
		u_raw_source_model.send(2, 8'h30, 1'b1);
		rdc(rst, 32'h30C, 32'h20C);
		u_raw_source_model.send(2, 8'h40, 1'b1);
		drain(2, 8'h30);
		rdc(rl, full, 32'h0);
		xfer(rst, 1'b1, 32'h4);
		rdc(rst, 32'h304, 32'h300);
		u_raw_source_model.send(2, 8'h50, 1'b1);
		drain(2, 8'h50);
		$display("test single ended");
	endtask : t_single
	task t_noncont;
		setup(32'h2, 32'h0, 32'h1);
		rdc(rst, 32'h300, 32'h300);
		u_raw_source_model.send(2, 8'h60, 1'b1);
		rdc(rst, 32'h304, 32'h304);
		u_raw_source_model.send(2, 8'h70, 1'b1);
		rdc(rst, 32'h304, 32'h204);
		drain(2, 8'h60);
		drain(2, 8'h70);
		$display("test noncontinuous ended");
	endtask : t_noncont
	task t_sync;
		setup(32'h2, 32'h0, 32'h7);
		rdc(rst, 32'h300, 32'h100);
		u_raw_source_model.send(2, 8'h80, 1'b1);
		rdc(rn, full, 32'h0);
		pulses(1, 1'b1);
		rdc(rst, 32'h300, 32'h100);
		pulses(1, 1'b1);
		rdc(rst, 32'h300, 32'h300);
		pulses(3, 1'b0);
		rdc(rst, 32'h0FFF0000, 32'h00030000);
		u_raw_source_model.send(2, 8'h90, 1'b1);
		drain(2, 8'h90);
		rdc(rl, full, 32'h0);
		$display("test sync ended");
	endtask : t_sync
	task t_field;
		setup(32'h2, 32'h0, 32'h45);
		field_identity_input <= 1'b1;
		u_raw_source_model.send(2, 8'hA0, 1'b1);
		rdc(rst, 32'h27, 32'h26);
		xfer(rst, 1'b1, 32'h1F);
		field_identity_input <= 1'b0;
		u_raw_source_model.send(2, 8'hB0, 1'b1);
		rdc(rst, 32'h27, 32'h01);
		drain(2, 8'hA0);
		drain(2, 8'hB0);
		$display("test field ended");
	endtask : t_field
	task t_dma;
		setup(32'h6, 32'h2, 32'h5);
		n_evt = 0;
		u_raw_source_model.send(6, 8'hC0, 1'b1);
		chk(32'(n_evt), 32'h3, "dma events");
		drain(6, 8'hC0);
		$display("test dma ended");
	endtask : t_dma
	// qualify held low: clock edges alone must not capture
	task t_ignore;
		setup(32'h2, 32'h0, 32'h5);
		u_raw_source_model.send(3, 8'hD0, 1'b0);
		rdc(rn, full, 32'h0);
		rdc(rl, full, 32'h0);
		$display("test ignore ended");
	endtask : t_ignore
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude
	////////////////////////////////////////////////
	// reset for five cycles, then run every scenario in turn
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		{field_identity_input, vertical_blank, line_start} = 3'b000;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_cont();
		t_split();
		t_single();
		t_noncont();
		t_sync();
		t_field();
		t_dma();
		t_ignore();
		conclude();
	end
endmodule : raw_data_capture_channel_tb

// *** dv/raw_source_model.sv ***
// sender-side model of the raw capture link: clock, qualify and samples
`timescale 1ns/1ps
module raw_source_model #(
	parameter int W = 8
) (
	output logic port_clock,
	output logic capture_qualify,
	output logic [W-1:0] raw_data
);
	////////////////////////////////////////////////
	// link idles with its clock still and qualify low
	initial begin
		port_clock = 1'b0;
		capture_qualify = 1'b0;
		raw_data = '0;
	end
	// one frame of n samples, then two qualify-low clocks before the clock stops
	task send(input int n, input logic [W-1:0] first, input logic qual);
		int i;
		for (i = 0; i < n + 2; i++) begin
			capture_qualify = qual && (i < n);
			raw_data = (i < n) ? first + W'(i) : ~raw_data; // released bus toggles
			#20 port_clock = 1'b1;
			#40 port_clock = 1'b0;
			#20;
		end
		raw_data = ~raw_data;
	endtask : send
endmodule : raw_source_model

// *** rtl/capture_fifo.sv ***
// sample buffer between the capture logic and the luma read port
`timescale 1ns/1ps
module capture_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 5120
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [$clog2(DEPTH+1)-1:0] limit,
	input wire logic push_valid,
	input wire logic [WIDTH-1:0] push_data,
	output logic push_ready,
	output logic pop_valid,
	input wire logic pop_ready,
	output logic [WIDTH-1:0] pop_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	initial begin
		if (WIDTH < 1 || DEPTH < 2)
			$error("capture_fifo: WIDTH or DEPTH too small");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [CW-1:0] count;
	} fifo_s;

	fifo_s cur_r;
	fifo_s cur_nxt;
	logic do_push;
	logic do_pop;

	// full follows the programmed limit so dual-channel use sees half the space
	assign push_ready = (cur_r.count < limit);
	assign pop_valid = (cur_r.count != '0);
	assign pop_data = cur_r.mem[cur_r.rd_ptr];
	assign level = cur_r.count;
	assign do_push = push_valid && push_ready;
	assign do_pop = pop_valid && pop_ready;

	// pointer and occupancy update
	always_comb begin
		cur_nxt = cur_r;
		if (do_push) begin
			cur_nxt.mem[cur_r.wr_ptr] = push_data;
			cur_nxt.wr_ptr = (cur_r.wr_ptr == AW'(DEPTH-1)) ? '0 : cur_r.wr_ptr + 1'b1;
		end
		if (do_pop) begin
			cur_nxt.rd_ptr = (cur_r.rd_ptr == AW'(DEPTH-1)) ? '0 : cur_r.rd_ptr + 1'b1;
		end
		if (do_push && !do_pop) begin
			cur_nxt.count = cur_r.count + 1'b1;
		end else if (do_pop && !do_push) begin
			cur_nxt.count = cur_r.count - 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur_r <= '0;
		end else begin
			cur_r <= cur_nxt;
		end
	end
endmodule : capture_fifo

// *** rtl/raw_capture_pkg.sv ***
// shared constants for the raw data capture channel
package raw_capture_pkg;
	// register byte offsets
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] stop_off = 8'h04;
	localparam logic [7:0] thrld_off = 8'h08;
	localparam logic [7:0] status_off = 8'h0C;
	localparam logic [7:0] count_off = 8'h10;
	localparam logic [7:0] luma_off = 8'h14;
	// control field positions
	localparam int ctl_enable = 0;
	localparam int ctl_sse = 1;
	localparam int ctl_con = 2;
	localparam int ctl_frame = 3;
	localparam int ctl_cf1 = 4;
	localparam int ctl_cf2 = 5;
	localparam int ctl_raw_field_detect_enable = 6;
	localparam int ctl_single = 7;
	localparam int ctl_scale = 8;
	localparam int ctl_resmpl = 9;
	localparam int ctl_bits = 10;
	// status field positions, flags 0..4 are write-one-to-clear
	localparam int st_f1c = 0;
	localparam int st_f2c = 1;
	localparam int st_frame_complete_flag = 2;
	localparam int st_ccmp = 3;
	localparam int st_ovf = 4;
	localparam int st_field = 5;
	localparam int st_state = 8;
	localparam int st_vline = 16;
	// stop value layout
	localparam int stop_half = 12;
	localparam int stop_bits = 24;
	localparam int thr_bits = 12;
	// reset values
	localparam logic [9:0] ctrl_reset = 10'h000;
	localparam logic [23:0] stop_reset = 24'h000000;
	localparam logic [11:0] thr_reset = 12'h000;
	// capture buffer sizes in bytes
	localparam int fifo_single_bytes = 5120;
	localparam int fifo_dual_bytes = 2560;
	// setup sync waits for this many blanking intervals
	localparam logic [1:0] sync_vblanks = 2'h2;
	// capture sequencer, gray along idle-sync-active-halt
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_sync = 2'b01,
		st_active = 2'b11,
		st_halt = 2'b10
	} cap_state_e;
endpackage : raw_capture_pkg

// *** rtl/raw_data_capture_channel.sv ***
// raw data capture channel with ahb-lite register access
//
// Notes on behaviour
// - sample only on sender clock with qualify
// - sample values never steer capture
// - setup sync waits two vertical blanks
// - without setup sync, start at enable
// - buffer 2560 bytes dual, 5120 single
// - luma read port pops samples, writes ignored
// - stop size: horizontal low, vertical high
// - count reaching stop ends block, sets flag
// - dma event every threshold new samples
// - field sampled at block start, channel a
// - field mode uses continuous/frame/field bits
// - no field info: block is a frame
// - noncontinuous: halt after next unless cleared
// - single frame: halt until flag cleared
// - continuous keeps capturing; both set reserved
// - blanking start resets vertical line counter
// - blanking data buffered like samples
// - filters always off in raw mode
`timescale 1ns/1ps
module raw_data_capture_channel #(
	parameter int DATA_WIDTH = 8,
	parameter bit CHANNEL_A = 1'b1
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic port_clock,
	input wire logic capture_qualify,
	input wire logic [DATA_WIDTH-1:0] raw_data,
	input wire logic field_identity_input,
	input wire logic vertical_blank,
	input wire logic line_start,
	output logic luma_dma_event,
	output logic capture_complete_irq_flag
);
	localparam int SB = raw_capture_pkg::fifo_single_bytes;
	localparam int DB = raw_capture_pkg::fifo_dual_bytes;
	localparam int DEPTH = SB / ((DATA_WIDTH + 7) / 8);
	localparam int LW = $clog2(DEPTH+1);
	localparam int CB = raw_capture_pkg::ctl_bits;

	initial begin
		if (DATA_WIDTH < 1 || DATA_WIDTH > 32)
			$error("raw_data_capture_channel: DATA_WIDTH must be 1 to 32");
	end

	typedef struct packed {
		raw_capture_pkg::cap_state_e state;
		logic pclk_s1;
		logic pclk_s2;
		logic pclk_s3;
		logic qual_s1;
		logic qual_s2;
		logic [DATA_WIDTH-1:0] data_s1;
		logic [DATA_WIDTH-1:0] data_s2;
		logic fid_s1;
		logic fid_s2;
		logic vbl_s1;
		logic vbl_s2;
		logic vbl_s3;
		logic line_s1;
		logic line_s2;
		logic line_s3;
		logic [CB-1:0] ctrl;
		logic [raw_capture_pkg::stop_bits-1:0] stop;
		logic [raw_capture_pkg::thr_bits-1:0] thr;
		logic [raw_capture_pkg::stop_bits-1:0] count;
		logic [raw_capture_pkg::thr_bits-1:0] evt_count;
		logic [1:0] vbl_seen;
		logic [11:0] vline;
		logic field;
		logic f1c;
		logic f2c;
		logic frame_complete_flag;
		logic ccmp;
		logic ovf;
		logic dma_evt;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} chan_s;

	chan_s cur_r;
	chan_s cur_nxt;
	logic push_ready;
	logic pop_valid;
	logic [DATA_WIDTH-1:0] pop_data;
	logic [LW-1:0] level;
	logic [LW-1:0] limit;
	logic take;
	logic rd_pop;
	logic sample;
	logic push;
	logic block_done;
	logic pclk_rise;

	// the low byte of the address selects the register
	function automatic logic is_reg(input logic [31:0] a, input logic [7:0] off);
		is_reg = (a[31:8] == 24'h000000) && (a[7:0] == off);
	endfunction : is_reg

	//////////////////////////////////////////////////////////////////////////
	// bus slave: zero wait states, read data registered in the address phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = cur_r.rdata;
	assign take = hsel && htrans[1] && hready;
	assign rd_pop = take && !hwrite && is_reg(haddr, raw_capture_pkg::luma_off);
	assign capture_complete_irq_flag = cur_r.ccmp;
	assign luma_dma_event = cur_r.dma_evt;

	//////////////////////////////////////////////////////////////////////////
	// capture qualification on the recovered sender clock edge
	assign pclk_rise = cur_r.pclk_s2 && !cur_r.pclk_s3;
	// qualify, the clock edge and the active state gate the sample, never the data value
	assign sample = pclk_rise && cur_r.qual_s2 && (cur_r.state == raw_capture_pkg::st_active);
	// blanking-interval words enter the luma buffer untouched
	assign push = sample && push_ready;
	assign block_done = sample && (cur_r.count + 1'b1 == cur_r.stop);
	// dual-channel mode gets half the storage
	assign limit = cur_r.ctrl[raw_capture_pkg::ctl_single] ? LW'(DEPTH)
		: LW'(DEPTH * DB / SB);

	capture_fifo #(
		.WIDTH(DATA_WIDTH),
		.DEPTH(DEPTH)
	) u_fifo (
		.hclk(hclk),
		.hresetn(hresetn),
		.limit(limit),
		.push_valid(push),
		.push_data(cur_r.data_s2),
		.push_ready(push_ready),
		.pop_valid(pop_valid),
		.pop_ready(rd_pop),
		.pop_data(pop_data),
		.level(level)
	);

	//////////////////////////////////////////////////////////////////////////
	// next-state logic for the whole channel
	always_comb begin
		logic fld_mode;
		logic fld_ok;
		logic set_f1;
		logic set_f2;
		logic set_fr;
		logic [31:0] w;
		fld_mode = 1'b0;
		fld_ok = 1'b1;
		set_f1 = 1'b0;
		set_f2 = 1'b0;
		set_fr = 1'b0;
		w = hwdata;
		cur_nxt = cur_r;
		// pins pass two flops before use
		cur_nxt.pclk_s1 = port_clock;
		cur_nxt.pclk_s2 = cur_r.pclk_s1;
		cur_nxt.pclk_s3 = cur_r.pclk_s2;
		cur_nxt.qual_s1 = capture_qualify;
		cur_nxt.qual_s2 = cur_r.qual_s1;
		cur_nxt.data_s1 = raw_data;
		cur_nxt.data_s2 = cur_r.data_s1;
		cur_nxt.fid_s1 = field_identity_input;
		cur_nxt.fid_s2 = cur_r.fid_s1;
		cur_nxt.vbl_s1 = vertical_blank;
		cur_nxt.vbl_s2 = cur_r.vbl_s1;
		cur_nxt.vbl_s3 = cur_r.vbl_s2;
		cur_nxt.line_s1 = line_start;
		cur_nxt.line_s2 = cur_r.line_s1;
		cur_nxt.line_s3 = cur_r.line_s2;
		cur_nxt.dma_evt = 1'b0;
		// field tracking only exists on channel a with detect enabled
		fld_mode = CHANNEL_A && cur_r.ctrl[raw_capture_pkg::ctl_raw_field_detect_enable];

		// vertical line counter restarts at each blanking start
		if (cur_r.vbl_s2 && !cur_r.vbl_s3) begin
			cur_nxt.vline = '0;
		end else if (cur_r.line_s2 && !cur_r.line_s3) begin
			cur_nxt.vline = cur_r.vline + 1'b1;
		end

		// field latched at each block start
		if (fld_mode && cur_r.count == '0 && pclk_rise && cur_r.qual_s2) begin
			cur_nxt.field = cur_r.fid_s2;
		end
		if (fld_mode) begin
			fld_ok = cur_nxt.field ? cur_r.ctrl[raw_capture_pkg::ctl_cf2]
				: cur_r.ctrl[raw_capture_pkg::ctl_cf1];
			if (!cur_r.ctrl[raw_capture_pkg::ctl_cf1] && !cur_r.ctrl[raw_capture_pkg::ctl_cf2])
				fld_ok = 1'b1;
		end

		// data count and completion flags
		if (block_done) begin
			cur_nxt.count = '0;
			if (fld_mode && fld_ok) begin
				set_f1 = !cur_nxt.field;
				set_f2 = cur_nxt.field;
				set_fr = cur_nxt.field || cur_r.ctrl[raw_capture_pkg::ctl_frame];
			end else if (!fld_mode) begin
				set_fr = 1'b1;
			end
		end else if (sample) begin
			cur_nxt.count = cur_r.count + 1'b1;
		end
		if (sample && !push_ready) begin
			cur_nxt.ovf = 1'b1;
		end

		// dma event each time the threshold of new samples is reached
		if (push && cur_r.thr != '0) begin
			if (cur_r.evt_count + 1'b1 == cur_r.thr) begin
				cur_nxt.evt_count = '0;
				cur_nxt.dma_evt = 1'b1;
			end else begin
				cur_nxt.evt_count = cur_r.evt_count + 1'b1;
			end
		end

		// register writes in the data phase; flags are write-one-to-clear
		if (cur_r.wr_pend) begin
			if (cur_r.wr_addr == raw_capture_pkg::ctrl_off) begin
				cur_nxt.ctrl = w[CB-1:0];
			end else if (cur_r.wr_addr == raw_capture_pkg::stop_off) begin
				cur_nxt.stop = w[raw_capture_pkg::stop_bits-1:0];
			end else if (cur_r.wr_addr == raw_capture_pkg::thrld_off) begin
				cur_nxt.thr = w[raw_capture_pkg::thr_bits-1:0];
			end else if (cur_r.wr_addr == raw_capture_pkg::status_off) begin
				if (w[raw_capture_pkg::st_f1c]) cur_nxt.f1c = 1'b0;
				if (w[raw_capture_pkg::st_f2c]) cur_nxt.f2c = 1'b0;
				if (w[raw_capture_pkg::st_frame_complete_flag]) cur_nxt.frame_complete_flag = 1'b0;
				if (w[raw_capture_pkg::st_ccmp]) cur_nxt.ccmp = 1'b0;
				if (w[raw_capture_pkg::st_ovf]) cur_nxt.ovf = 1'b0;
			end
		end
		// hardware set wins over a clear in the same cycle
		if (set_f1) cur_nxt.f1c = 1'b1;
		if (set_f2) cur_nxt.f2c = 1'b1;
		if (set_fr) cur_nxt.frame_complete_flag = 1'b1;
		if (set_f1 || set_f2 || set_fr) cur_nxt.ccmp = 1'b1;
		if (sample && !push_ready) cur_nxt.ovf = 1'b1;

		// capture sequencer
		case (cur_r.state)
			raw_capture_pkg::st_idle: begin
				cur_nxt.vbl_seen = '0;
				cur_nxt.count = '0;
				if (cur_r.ctrl[raw_capture_pkg::ctl_enable]) begin
					if (cur_r.ctrl[raw_capture_pkg::ctl_sse])
						cur_nxt.state = raw_capture_pkg::st_sync;
					else
						cur_nxt.state = raw_capture_pkg::st_active;
				end
			end
			raw_capture_pkg::st_sync: begin
				if (cur_r.vbl_s2 && !cur_r.vbl_s3) begin
					cur_nxt.vbl_seen = cur_r.vbl_seen + 1'b1;
					if (cur_r.vbl_seen + 1'b1 == raw_capture_pkg::sync_vblanks)
						cur_nxt.state = raw_capture_pkg::st_active;
				end
			end
			raw_capture_pkg::st_active: begin
				// continuous keeps going; frame halts; noncontinuous halts if uncleared
				if (block_done && !cur_r.ctrl[raw_capture_pkg::ctl_con]) begin
					if (cur_r.ctrl[raw_capture_pkg::ctl_frame] && set_fr)
						cur_nxt.state = raw_capture_pkg::st_halt;
					else if (cur_r.frame_complete_flag && set_fr)
						cur_nxt.state = raw_capture_pkg::st_halt;
				end
			end
			raw_capture_pkg::st_halt: begin
				if (!cur_r.frame_complete_flag)
					cur_nxt.state = raw_capture_pkg::st_active;
			end
			default: cur_nxt.state = raw_capture_pkg::st_idle;
		endcase
		// dropping enable parks the sequencer and forgets the partial block at once
		if (!cur_r.ctrl[raw_capture_pkg::ctl_enable]) begin
			cur_nxt.state = raw_capture_pkg::st_idle;
			cur_nxt.count = '0;
		end

		// address phase: capture writes, prepare read data
		cur_nxt.wr_pend = take && hwrite;
		cur_nxt.wr_addr = haddr[31:8] == 24'h000000 ? haddr[7:0] : 8'hFF;
		if (take && !hwrite) begin
			cur_nxt.rdata = 32'h00000000;
			if (is_reg(haddr, raw_capture_pkg::ctrl_off)) begin
				cur_nxt.rdata[CB-1:0] = cur_r.ctrl;
			end else if (is_reg(haddr, raw_capture_pkg::stop_off)) begin
				cur_nxt.rdata[raw_capture_pkg::stop_bits-1:0] = cur_r.stop;
			end else if (is_reg(haddr, raw_capture_pkg::thrld_off)) begin
				cur_nxt.rdata[raw_capture_pkg::thr_bits-1:0] = cur_r.thr;
			end else if (is_reg(haddr, raw_capture_pkg::status_off)) begin
				cur_nxt.rdata[raw_capture_pkg::st_f1c] = cur_r.f1c;
				cur_nxt.rdata[raw_capture_pkg::st_f2c] = cur_r.f2c;
				cur_nxt.rdata[raw_capture_pkg::st_frame_complete_flag] = cur_r.frame_complete_flag;
				cur_nxt.rdata[raw_capture_pkg::st_ccmp] = cur_r.ccmp;
				cur_nxt.rdata[raw_capture_pkg::st_ovf] = cur_r.ovf;
				cur_nxt.rdata[raw_capture_pkg::st_field] = cur_r.field;
				cur_nxt.rdata[raw_capture_pkg::st_state +: 2] = cur_r.state;
				cur_nxt.rdata[raw_capture_pkg::st_vline +: 12] = cur_r.vline;
			end else if (is_reg(haddr, raw_capture_pkg::count_off)) begin
				cur_nxt.rdata[raw_capture_pkg::stop_bits-1:0] = cur_r.count;
			end else if (is_reg(haddr, raw_capture_pkg::luma_off)) begin
				// empty buffer reads as zero rather than stale data
				if (pop_valid)
					cur_nxt.rdata[DATA_WIDTH-1:0] = pop_data;
			end
		end
	end

	// scale and re-sample bits are held for software but never reach a filter
	// since raw samples must pass bit-exact; there is no filter in this path

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur_r <= '0;
			cur_r.state <= raw_capture_pkg::st_idle;
			cur_r.ctrl <= raw_capture_pkg::ctrl_reset;
			cur_r.stop <= raw_capture_pkg::stop_reset;
			cur_r.thr <= raw_capture_pkg::thr_reset;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// checks on the channel behaviour
	a_no_sample_unqual: assert property (@(posedge hclk) disable iff (!hresetn)
		!cur_r.qual_s2 |-> ##1 (cur_r.count == $past(cur_r.count) || cur_r.count == '0))
		else $error("count moved without qualify");

	a_start_no_sync: assert property (@(posedge hclk) disable iff (!hresetn)
		(cur_r.state == raw_capture_pkg::st_idle && cur_r.ctrl[raw_capture_pkg::ctl_enable]
		&& !cur_r.ctrl[raw_capture_pkg::ctl_sse]) |=> cur_r.state == raw_capture_pkg::st_active)
		else $error("capture did not start at enable");

	a_sync_two_blanks: assert property (@(posedge hclk) disable iff (!hresetn)
		($past(cur_r.state) == raw_capture_pkg::st_sync
		&& cur_r.state == raw_capture_pkg::st_active)
		|-> $past(cur_r.vbl_seen) == 2'h1)
		else $error("setup sync left early");

	a_block_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		(block_done && !(CHANNEL_A && cur_r.ctrl[raw_capture_pkg::ctl_raw_field_detect_enable]))
		|=> cur_r.frame_complete_flag && cur_r.ccmp && cur_r.count == '0)
		else $error("block end did not flag or restart count");

	a_single_halts: assert property (@(posedge hclk) disable iff (!hresetn)
		(block_done && cur_r.ctrl[raw_capture_pkg::ctl_enable] && !cur_r.ctrl[raw_capture_pkg::ctl_con]
		&& cur_r.ctrl[raw_capture_pkg::ctl_frame] && !cur_r.ctrl[raw_capture_pkg::ctl_raw_field_detect_enable])
		|=> cur_r.state == raw_capture_pkg::st_halt)
		else $error("single frame did not halt");

	a_cont_runs: assert property (@(posedge hclk) disable iff (!hresetn)
		(cur_r.state == raw_capture_pkg::st_active && cur_r.ctrl[raw_capture_pkg::ctl_con]
		&& cur_r.ctrl[raw_capture_pkg::ctl_enable])
		|=> cur_r.state == raw_capture_pkg::st_active)
		else $error("continuous capture stopped");

	a_halt_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		(cur_r.state == raw_capture_pkg::st_halt && cur_r.frame_complete_flag && cur_r.ctrl[raw_capture_pkg::ctl_enable]
		&& !cur_r.wr_pend) |=> cur_r.state == raw_capture_pkg::st_halt)
		else $error("halt released with flag set");

	a_dma_event_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		luma_dma_event |-> ($past(push) && $past(cur_r.evt_count) + 1'b1 == $past(cur_r.thr))
		##1 !luma_dma_event)
		else $error("dma event not at threshold");

	a_vline_reset: assert property (@(posedge hclk) disable iff (!hresetn)
		(cur_r.vbl_s2 && !cur_r.vbl_s3) |=> cur_r.vline == 12'h000)
		else $error("line counter not reset at blanking");

	a_luma_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		push |=> u_fifo.cur_r.mem[$past(u_fifo.cur_r.wr_ptr)] == $past(cur_r.data_s2))
		else $error("sample altered on its way in");
endmodule : raw_data_capture_channel
